// *** include/odst_params.svh ***
/*
  Timing constants for the opcode decode and state-timing block.
  Assumes inclusion by the design files of this block only.
*/
`ifndef ODST_PARAMS_SVH
`define ODST_PARAMS_SVH

// ----------------------------------------------------------------
// instruction word fields
// ----------------------------------------------------------------
`define ODST_OP_HI        15
`define ODST_OP_LO        8
`define ODST_GROUP_BIT    7

// ----------------------------------------------------------------
// states per cycle type
// ----------------------------------------------------------------
`define ODST_MEM_STATES   3'h2
`define ODST_INT_STATES   3'h1
`define ODST_PER_SLOW     3'h3
`define ODST_PER_FAST     3'h2

`endif

// *** include/odst_pkg.sv ***
/*
  Types shared by the opcode decode and state-timing block.
  Assumes the params header sits on the include path.
*/
package odst_pkg;

    // ------------------------------------------------------------
    // operation classes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ODST_REG_ALU,
        ODST_FLAGS_OP,
        ODST_SHORT_BRANCH,
        ODST_BIT_TEST_MEM,
        ODST_BIT_MODIFY_MEM,
        ODST_BIT_REG,
        ODST_MOVE_REG,
        ODST_BRANCH_SUB,
        ODST_JUMP_IND,
        ODST_RETURN,
        ODST_BLOCK_MOVE,
        ODST_OTHER
    } odst_class_t;

    // per-type cycle counts
    typedef struct packed {
        logic [2:0] fetch;
        logic [2:0] branch_read;
        logic [2:0] stack;
        logic [2:0] byte_acc;
        logic [2:0] word_acc;
        logic [2:0] internal;
    } odst_counts_t;

    // decoded instruction record
    typedef struct packed {
        logic [7:0]   opcode;
        logic         group_hi;
        odst_class_t  op_class;
        odst_counts_t counts;
    } odst_decode_t;

endpackage : odst_pkg

// *** logic/odst_state_sum.sv ***
/*
  Combinational total of execution states from cycle counts.
  Assumes the byte-access state count already reflects the target.
*/
`timescale 1ns/1ps
`include "odst_params.svh"

module odst_state_sum
    import odst_pkg::*;
(
    input  wire odst_counts_t counts,
    input  wire logic [2:0]   byte_states,
    output logic [7:0]        total
);

    // ------------------------------------------------------------
    // weighted sum
    // ------------------------------------------------------------
    function automatic logic [7:0] mul(input logic [2:0] n, input logic [2:0] s);
        // widen first so a product above seven cannot wrap at three bits
        mul = 8'(n) * 8'(s);
    endfunction : mul

    always_comb begin
        total = mul(counts.fetch, `ODST_MEM_STATES)
              + mul(counts.branch_read, `ODST_MEM_STATES)
              + mul(counts.stack, `ODST_MEM_STATES)
              + mul(counts.byte_acc, byte_states)
              + mul(counts.word_acc, `ODST_MEM_STATES)
              + mul(counts.internal, `ODST_INT_STATES);
    end

endmodule : odst_state_sum

// *** logic/odst_decoder.sv ***
/*
  Opcode decoder with per-type cycle counts and total execution states.
  Assumes an instruction word presented with a one-cycle valid strobe and
  a peripheral-select level saying whether byte data goes to a peripheral, plus a level saying if it is slow.
*/
`timescale 1ns/1ps
`include "odst_params.svh"

module odst_decoder
    import odst_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic         instr_valid,
    input  wire logic [15:0]  instr_word,
    input  wire logic         byte_to_periph,
    input  wire logic         periph_slow,
    output odst_decode_t      decoded,
    output logic              decoded_valid,
    output logic [7:0]        exec_states
);

    // ------------------------------------------------------------
    // count builder
    // ------------------------------------------------------------
    function automatic odst_counts_t cnt(input logic [2:0] i, input logic [2:0] j,
                                         input logic [2:0] k, input logic [2:0] l,
                                         input logic [2:0] m, input logic [2:0] n);
        cnt = '{fetch: i, branch_read: j, stack: k, byte_acc: l, word_acc: m,
                internal: n};
    endfunction : cnt

    logic [7:0]   opcode;
    logic         group_hi;
    odst_class_t  op_class;
    odst_counts_t counts;
    logic [2:0]   byte_states;
    logic [7:0]   total;
    odst_decode_t next_decoded;
    logic         next_valid;
    logic [7:0]   next_states;

    assign opcode   = instr_word[`ODST_OP_HI:`ODST_OP_LO];
    assign group_hi = instr_word[`ODST_GROUP_BIT];

    // opcode to class
    always_comb begin
        op_class = ODST_OTHER;
        case (opcode[7:4])
            4'h0: op_class = (opcode == 8'h06) ? ODST_FLAGS_OP : ODST_REG_ALU;
            4'h1: op_class = ODST_REG_ALU;
            4'h4: op_class = ODST_SHORT_BRANCH;
            4'h5: begin
                case (opcode[3:0])
                    4'h4, 4'h6: op_class = ODST_RETURN;
                    4'h5:       op_class = ODST_BRANCH_SUB;
                    4'h9, 4'hB, 4'hD, 4'hF: op_class = ODST_JUMP_IND;
                    default:    op_class = ODST_OTHER;
                endcase
            end
            4'h6: begin
                if (opcode[3]) begin
                    op_class = ODST_MOVE_REG;
                end else begin
                    op_class = ODST_BIT_REG;
                end
            end
            4'h7: begin
                case (opcode[3:0])
                    4'hB:       op_class = ODST_BLOCK_MOVE;
                    4'hC, 4'hE: op_class = ODST_BIT_TEST_MEM;
                    4'hD, 4'hF: op_class = group_hi ? ODST_OTHER : ODST_BIT_MODIFY_MEM;
                    default:    op_class = ODST_BIT_REG;
                endcase
            end
            4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: op_class = ODST_REG_ALU;
            default: op_class = ODST_OTHER;
        endcase
        if (opcode >= 8'h02 && opcode <= 8'h07) begin
            op_class = ODST_FLAGS_OP;
        end
    end

    always_comb begin
        case (op_class)
            ODST_REG_ALU, ODST_FLAGS_OP, ODST_BIT_REG, ODST_MOVE_REG:
                counts = cnt(3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0);
            ODST_SHORT_BRANCH: counts = cnt(3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0);
            ODST_BIT_TEST_MEM: counts = cnt(3'h2, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0);
            ODST_BIT_MODIFY_MEM: counts = cnt(3'h2, 3'h0, 3'h0, 3'h2, 3'h0, 3'h0);
            ODST_BRANCH_SUB:   counts = cnt(3'h2, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0);
            ODST_JUMP_IND:     counts = cnt(3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0);
            ODST_RETURN:       counts = cnt(3'h2, 3'h0, 3'h1, 3'h0, 3'h0, 3'h2);
            ODST_BLOCK_MOVE:   counts = cnt(3'h2, 3'h0, 3'h0, 3'h2, 3'h0, 3'h1);
            default:           counts = cnt(3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0);
        endcase
    end

    always_comb begin
        if (byte_to_periph) begin
            byte_states = periph_slow ? `ODST_PER_SLOW : `ODST_PER_FAST;
        end else begin
            byte_states = `ODST_MEM_STATES;
        end
    end

    odst_state_sum u_sum (
        .counts      (counts),
        .byte_states (byte_states),
        .total       (total)
    );

    // next output values
    always_comb begin
        next_decoded = decoded;
        next_states  = exec_states;
        next_valid   = instr_valid;
        if (instr_valid) begin
            next_decoded = '{opcode: opcode, group_hi: group_hi, op_class: op_class,
                             counts: counts};
            next_states  = total;
        end
    end

    // output registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            decoded       <= '0;
            decoded_valid <= 1'b0;
            exec_states   <= 8'h00;
        end else begin
            decoded       <= next_decoded;
            decoded_valid <= next_valid;
            exec_states   <= next_states;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_opcode_field;
        @(posedge clock) disable iff (!reset_n)
        instr_valid |=> decoded.opcode == $past(instr_word[15:8]);
    endproperty
    a_opcode_field: assert property (p_opcode_field) else $error("opcode field wrong");

    property p_group_bit;
        @(posedge clock) disable iff (!reset_n)
        instr_valid |=> decoded.group_hi == $past(instr_word[7]);
    endproperty
    a_group_bit: assert property (p_group_bit) else $error("group bit wrong");

    property p_push_move;
        @(posedge clock) disable iff (!reset_n)
        (instr_valid && instr_word[15:12] == 4'h6 && instr_word[11]) |=>
            decoded.op_class == ODST_MOVE_REG;
    endproperty
    a_push_move: assert property (p_push_move) else $error("push not move");

    property p_alu_states;
        @(posedge clock) disable iff (!reset_n)
        (instr_valid && instr_word[15:12] == 4'h8) |=> exec_states == 8'h02;
    endproperty
    a_alu_states: assert property (p_alu_states) else $error("alu states wrong");

    property p_branch_fetch;
        @(posedge clock) disable iff (!reset_n)
        (instr_valid && instr_word[15:12] == 4'h4) |=>
            decoded.counts.fetch == 3'h2 && decoded.counts.byte_acc == 3'h0;
    endproperty
    a_branch_fetch: assert property (p_branch_fetch) else $error("branch counts wrong");

    property p_bit_clear_op_mem;
        @(posedge clock) disable iff (!reset_n)
        (instr_valid && instr_word[15:8] == 8'h7D && !instr_word[7] && !byte_to_periph)
            |=> decoded.counts.byte_acc == 3'h2 && exec_states == 8'h08;
    endproperty
    a_bit_clear_op_mem: assert property (p_bit_clear_op_mem) else $error("bit clear timing wrong");

    property p_periph_slow;
        @(posedge clock) disable iff (!reset_n)
        (instr_valid && instr_word[15:8] == 8'h7C && byte_to_periph && periph_slow)
            |=> exec_states == 8'h07;
    endproperty
    a_periph_slow: assert property (p_periph_slow) else $error("slow periph wrong");

    property p_periph_fast;
        @(posedge clock) disable iff (!reset_n)
        (instr_valid && instr_word[15:8] == 8'h7C && byte_to_periph && !periph_slow)
            |=> exec_states == 8'h06;
    endproperty
    a_periph_fast: assert property (p_periph_fast) else $error("fast periph wrong");

    property p_bit_test_mem;
        @(posedge clock) disable iff (!reset_n)
        (instr_valid && instr_word[15:8] == 8'h7E) |=>
            decoded.counts.fetch == 3'h2 && decoded.counts.byte_acc == 3'h1;
    endproperty
    a_bit_test_mem: assert property (p_bit_test_mem) else $error("bit test counts wrong");

    property p_sum;
        @(posedge clock) disable iff (!reset_n)
        decoded_valid |-> exec_states >= {4'h0, decoded.counts.fetch, 1'b0};
    endproperty
    a_sum: assert property (p_sum) else $error("state sum too small");

    // answer pulse, then valid tracks the strobe one edge late
    sequence s_answer;
        decoded_valid ##1 (decoded_valid == $past(instr_valid));
    endsequence

    property p_valid_follow;
        @(posedge clock) disable iff (!reset_n)
        instr_valid |=> s_answer;
    endproperty
    a_valid_follow: assert property (p_valid_follow) else $error("valid lost");

endmodule : odst_decoder

// *** bench/odst_src_model.sv ***
/*
  Instruction source model: presents first instruction words to the decoder.
  Assumes the bench calls its tasks away from the rising clock edge.
*/
`timescale 1ns/1ps

module odst_src_model (
    output logic        instr_valid,
    output logic [15:0] instr_word,
    output logic        byte_to_periph,
    output logic        periph_slow
);
    // ------------------------------------------------------------
    // idle levels at time zero
    // ------------------------------------------------------------
    initial begin
        instr_valid    = 1'b0;
        instr_word     = 16'h0000;
        byte_to_periph = 1'b0;
        periph_slow    = 1'b0;
    end

    // present one word with its data target
    task automatic drive(input logic [15:0] w, input logic bp, input logic sl);
        instr_valid    = 1'b1;
        instr_word     = w;
        byte_to_periph = bp;
        periph_slow    = sl;
    endtask : drive

    // release: word and target scrambled so a stale value is never reused
    task automatic idle();
        instr_valid    = 1'b0;
        instr_word     = ~instr_word;
        byte_to_periph = ~byte_to_periph;
        periph_slow    = ~periph_slow;
    endtask : idle
endmodule : odst_src_model

// *** bench/tb_opcode_decode_state_timing.sv ***
/*
  Self-checking bench for the opcode decoder and state-timing logic.
  Assumes the source model drives the decoder inputs at falling edges.
*/
`timescale 1ns/1ps

module tb_opcode_decode_state_timing;
    import odst_pkg::*;
    logic         clock = 1'b0;
    logic         reset_n = 1'b0;
    logic         instr_valid;
    logic [15:0]  instr_word;
    logic         byte_to_periph;
    logic         periph_slow;
    odst_decode_t decoded;
    logic         decoded_valid;
    logic [7:0]   exec_states;
    int           error_cnt = 0;
    int           checks = 0;

    // ------------------------------------------------------------
    // clock, source and decoder
    // ------------------------------------------------------------
    always #4 clock = ~clock;

    odst_src_model src (
        .instr_valid(instr_valid), .instr_word(instr_word),
        .byte_to_periph(byte_to_periph), .periph_slow(periph_slow));

    odst_decoder uut (
        .clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .byte_to_periph(byte_to_periph),
        .periph_slow(periph_slow), .decoded(decoded),
        .decoded_valid(decoded_valid), .exec_states(exec_states));

    // ------------------------------------------------------------
    // compare helpers and expectations
    // ------------------------------------------------------------
    task automatic bad(input string m);
        error_cnt++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : bad
    task automatic cmp_bit(input logic g, input logic e, input string m);
        checks++;
        if (g !== e) bad(m);
    endtask : cmp_bit
    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e, input string m);
        checks++;
        if (g !== e) bad(m);
    endtask : cmp_byte
    task automatic cmp_cls(input odst_class_t g, input odst_class_t e);
        checks++;
        if (g !== e) bad("class");
    endtask : cmp_cls
    task automatic cmp_cnt(input odst_counts_t g, input odst_counts_t e);
        checks++;
        if (g !== e) bad("counts");
    endtask : cmp_cnt

    function automatic odst_counts_t mk(int f, int j, int k, int l, int m, int n);
        return '{3'(f), 3'(j), 3'(k), 3'(l), 3'(m), 3'(n)};
    endfunction : mk

    // memory cycles two states, internal one, slow peripheral byte three
    function automatic logic [7:0] tot(odst_counts_t c, logic bp, logic sl);
        int bs;
        bs = (bp && sl) ? 3 : 2;
        return 8'(2 * (c.fetch + c.branch_read + c.stack + c.word_acc)
                  + bs * c.byte_acc + c.internal);
    endfunction : tot

    // judge the answer standing one cycle after the taken word
    task automatic check(input logic [15:0] w, input odst_class_t cls, input logic full,
                         input odst_counts_t c, input logic [7:0] st);
        cmp_bit(decoded_valid, 1'b1, "valid");
        cmp_byte(decoded.opcode, w[15:8], "opcode");
        cmp_bit(decoded.group_hi, w[7], "group");
        cmp_cls(decoded.op_class, cls);
        if (full) begin
            cmp_cnt(decoded.counts, c);
            cmp_byte(exec_states, st, "states");
        end
    endtask : check

    task automatic one(input logic [15:0] w, input logic bp, input logic sl,
                       input odst_class_t cls, input logic full, input odst_counts_t c);
        @(negedge clock);
        src.drive(w, bp, sl);
        @(negedge clock);
        check(w, cls, full, c, tot(c, bp, sl));
        src.idle();
    endtask : one

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        @(negedge clock);
        cmp_bit(decoded_valid, 1'b0, "reset valid");
        cmp_byte(exec_states, 8'h00, "reset states");
        cmp_byte(decoded.opcode, 8'h00, "reset opcode");
        cmp_cnt(decoded.counts, mk(0, 0, 0, 0, 0, 0));
    endtask : t_reset

    task automatic t_alu();
        one(16'h0812, 1'b0, 1'b0, ODST_REG_ALU, 1'b1, mk(1, 0, 0, 0, 0, 0));
        one(16'h06F0, 1'b1, 1'b1, ODST_FLAGS_OP, 1'b1, mk(1, 0, 0, 0, 0, 0));
        one(16'h8A05, 1'b0, 1'b0, ODST_REG_ALU, 1'b1, mk(1, 0, 0, 0, 0, 0));
        one(16'h6010, 1'b0, 1'b0, ODST_BIT_REG, 1'b1, mk(1, 0, 0, 0, 0, 0));
    endtask : t_alu

    task automatic t_branch();
        logic [15:0] w;
        @(negedge clock);
        for (int i = 0; i < 16; i++) begin
            w = {4'h4, 4'(i), 8'h10};
            src.drive(w, 1'b0, 1'b0);
            @(negedge clock);
            check(w, ODST_SHORT_BRANCH, 1'b1, mk(2, 0, 0, 0, 0, 0), 8'h04);
        end
        src.idle();
        @(negedge clock);
        cmp_bit(decoded_valid, 1'b0, "pulse");
        cmp_byte(decoded.opcode, 8'h4F, "hold");
    endtask : t_branch

    task automatic t_bit();
        one(16'h7C00, 1'b0, 1'b0, ODST_BIT_TEST_MEM, 1'b1, mk(2, 0, 0, 1, 0, 0));
        one(16'h7C10, 1'b1, 1'b0, ODST_BIT_TEST_MEM, 1'b1, mk(2, 0, 0, 1, 0, 0));
        one(16'h7C20, 1'b1, 1'b1, ODST_BIT_TEST_MEM, 1'b1, mk(2, 0, 0, 1, 0, 0));
        one(16'h7E30, 1'b0, 1'b0, ODST_BIT_TEST_MEM, 1'b1, mk(2, 0, 0, 1, 0, 0));
        one(16'h7D00, 1'b0, 1'b0, ODST_BIT_MODIFY_MEM, 1'b1, mk(2, 0, 0, 2, 0, 0));
        one(16'h7F70, 1'b1, 1'b1, ODST_BIT_MODIFY_MEM, 1'b1, mk(2, 0, 0, 2, 0, 0));
        one(16'h7D80, 1'b0, 1'b0, ODST_OTHER, 1'b0, mk(0, 0, 0, 0, 0, 0));
    endtask : t_bit

    task automatic t_stack();
        one(16'h5F20, 1'b0, 1'b0, ODST_JUMP_IND, 1'b1, mk(2, 1, 1, 0, 0, 0));
        one(16'h5470, 1'b0, 1'b0, ODST_RETURN, 1'b1, mk(2, 0, 1, 0, 0, 2));
        one(16'h5510, 1'b0, 1'b0, ODST_BRANCH_SUB, 1'b1, mk(2, 0, 1, 0, 0, 0));
        one(16'h7B5C, 1'b0, 1'b0, ODST_BLOCK_MOVE, 1'b1, mk(2, 0, 0, 2, 0, 1));
        one(16'h6DF0, 1'b0, 1'b0, ODST_MOVE_REG, 1'b0, mk(0, 0, 0, 0, 0, 0));
        one(16'h6D70, 1'b0, 1'b0, ODST_MOVE_REG, 1'b0, mk(0, 0, 0, 0, 0, 0));
    endtask : t_stack

    // reset mid-run, word taken at release
    task automatic t_rerun();
        @(negedge clock);
        reset_n = 1'b0;
        src.drive(16'h7D00, 1'b0, 1'b0);
        @(negedge clock);
        cmp_bit(decoded_valid, 1'b0, "rerun valid");
        cmp_byte(decoded.opcode, 8'h00, "rerun opcode");
        cmp_byte(exec_states, 8'h00, "rerun states");
        reset_n = 1'b1;
        @(negedge clock);
        check(16'h7D00, ODST_BIT_MODIFY_MEM, 1'b1, mk(2, 0, 0, 2, 0, 0), 8'h08);
        src.idle();
    endtask : t_rerun

    // ------------------------------------------------------------
    // verdict, main sequence and watchdog
    // ------------------------------------------------------------
    task automatic complete_run();
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
        t_reset();
        t_alu();
        t_branch();
        t_bit();
        t_stack();
        t_rerun();
        complete_run();
    end

    initial begin
        #20000;
        error_cnt++;
        complete_run();
    end
endmodule : tb_opcode_decode_state_timing
